// >>> design/ncr_pkg.sv
// constants, types and helpers for the controller command register
// assumes a single 125 MHz clock domain for the whole register bank
package ncr_pkg;

  // ==========================================================
  // register map and field positions
  localparam logic [3:0] NCR_CMD_OFFSET = 4'h0;
  localparam int NCR_STOP_POS   = 0;
  localparam int NCR_START_POS  = 1;
  localparam int NCR_TXP_POS    = 2;
  localparam int NCR_RD_LSB     = 3;
  localparam int NCR_RD_MSB     = 5;
  localparam int NCR_PS_LSB     = 6;
  localparam int NCR_PS_MSB     = 7;
  // stopped, start clear, remote dma idle (abort code)
  localparam logic [7:0] NCR_CMD_RESET  = 8'h21;
  localparam logic [7:0] NCR_READ_EMPTY = 8'h00;

  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    NCR_RD_NONE  = 3'h0,
    NCR_RD_READ  = 3'h1,
    NCR_RD_WRITE = 3'h2,
    NCR_RD_SEND  = 3'h3,
    NCR_RD_ABORT = 3'h4
  } ncr_rdma_t;

  typedef enum logic [1:0] {
    NCR_RUNNING  = 2'h0,
    NCR_DRAINING = 2'h1,
    NCR_STOPPED  = 2'h2
  } ncr_run_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ncr_req_t;

  typedef struct packed {
    logic txBusy;
    logic rxBusy;
    logic txDone;
    logic txAbort;
    logic rdmaDone;
    logic rbcWrite;
    logic errReset;
    logic isrRstClear;
  } ncr_core_t;

  // ==========================================================
  // helpers
  function automatic ncr_rdma_t ncrDecodeRdma(input logic [2:0] bits);
    if (bits[2]) begin
      return NCR_RD_ABORT;
    end
    return ncr_rdma_t'(bits);
  endfunction

  function automatic logic [3:0] ncrPageDecode(input logic [1:0] ps);
    return 4'h1 << ps;
  endfunction

endpackage

// >>> design/ncr_run_ctrl.sv
// stop / start sequencing of the controller core and reset-complete flag
// assumes busy comes from logic on the same clock
module ncr_run_ctrl import ncr_pkg::*; (
  // clock and reset
  input  wire logic     clock,
  input  wire logic     resetn,
  input  wire logic     ce,
  // commands
  input  wire logic     stopCmd,
  input  wire logic     startCmd,
  input  wire logic     busy,
  input  wire logic     errReset,
  input  wire logic     rstClear,
  // status
  output ncr_run_t      runState,
  output logic          resetDone
);

  typedef struct packed {
    ncr_run_t st;
    logic     rstFlag;
  } ncr_run_state_t;

  ncr_run_state_t state;
  ncr_run_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state.st)
      NCR_RUNNING: begin
        if (stopCmd) begin
          next_state.st = busy ? NCR_DRAINING : NCR_STOPPED;
        end else if (errReset) begin
          next_state.st = NCR_STOPPED;
        end
      end
      NCR_DRAINING: begin
        if (startCmd) begin
          next_state.st = NCR_RUNNING;
        end else if (!busy) begin
          next_state.st = NCR_STOPPED;
        end
      end
      NCR_STOPPED: begin
        if (startCmd) begin
          next_state.st = NCR_RUNNING;
        end
      end
      default: next_state.st = NCR_STOPPED;
    endcase
    // clear first so that a new reset event wins
    if (rstClear || next_state.st != NCR_STOPPED) begin
      next_state.rstFlag = 1'b0;
    end
    if (next_state.st == NCR_STOPPED && state.st != NCR_STOPPED) begin
      next_state.rstFlag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state.st      <= NCR_STOPPED;
      state.rstFlag <= 1'b1;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign runState  = state.st;
  assign resetDone = state.rstFlag;

  // ==========================================================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence drainHold;
    ce && state.st == NCR_DRAINING && busy && !startCmd;
  endsequence

  drain_wait_a: assert property (drainHold |=> state.st == NCR_DRAINING)
    else $error("left draining while traffic still busy");
  reset_flag_a: assert property (ce && stopCmd && !busy && state.st == NCR_RUNNING |=> resetDone)
    else $error("reset-complete flag not raised after stop");
  restart_run_a: assert property (ce && startCmd && state.st == NCR_STOPPED |=> state.st == NCR_RUNNING)
    else $error("start did not reactivate core");

endmodule

// >>> design/ncr_rdma_ctrl.sv
// remote dma command field: start, abort and early completion
// assumes rdmaDone and rbcWrite come from the dma engine on the same clock
module ncr_rdma_ctrl import ncr_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ce,
  // command write
  input  wire logic       cmdWrite,
  input  wire logic [2:0] cmdBits,
  input  wire logic       txpBit,
  // engine status
  input  wire logic       rdmaDone,
  input  wire logic       rbcWrite,
  // outputs
  output logic [2:0]      rdField,
  output logic            active,
  output logic            startPulse,
  output logic            abortPulse,
  output logic            donePulse
);

  typedef struct packed {
    logic [2:0] bits;
    logic       active;
    logic       reloaded;
    logic       startP;
    logic       abortP;
    logic       doneP;
  } ncr_rdma_state_t;

  ncr_rdma_state_t state;
  ncr_rdma_state_t next_state;
  ncr_rdma_t       dec;

  always_comb begin
    next_state        = state;
    next_state.startP = 1'b0;
    next_state.abortP = 1'b0;
    next_state.doneP  = 1'b0;
    dec               = ncrDecodeRdma(cmdBits);
    if (rbcWrite) begin
      next_state.reloaded = 1'b1;
    end
    if (rdmaDone && state.active) begin
      next_state.active = 1'b0;
      next_state.bits   = NCR_RD_ABORT;
      next_state.doneP  = 1'b1;
    end
    if (cmdWrite) begin
      unique case (dec)
        NCR_RD_ABORT: begin
          // address counter is left where it stopped
          next_state.bits = cmdBits;
          if (next_state.active) begin
            next_state.active = 1'b0;
            next_state.abortP = 1'b1;
          end
        end
        NCR_RD_NONE: ;
        default: begin
          if (next_state.active) begin
            // mismatching command ignored: engine cannot switch direction
            if (cmdBits == state.bits && txpBit && !state.reloaded) begin
              next_state.active = 1'b0;
              next_state.bits   = NCR_RD_ABORT;
              next_state.doneP  = 1'b1;
            end
          end else begin
            next_state.bits     = cmdBits;
            next_state.active   = 1'b1;
            next_state.reloaded = rbcWrite;
            next_state.startP   = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '{bits: NCR_CMD_RESET[NCR_RD_MSB:NCR_RD_LSB], default: 1'b0};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign rdField    = state.bits;
  assign active     = state.active;
  assign startPulse = state.startP;
  assign abortPulse = state.abortP;
  assign donePulse  = state.doneP;

  // ==========================================================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // a count that runs out in the same cycle ends the dma as done, not aborted
  abort_stop_a: assert property (ce && cmdWrite && cmdBits[2] && active && !rdmaDone |=> !active && abortPulse)
    else $error("abort did not end remote dma");
  quick_done_a: assert property (ce && cmdWrite && active && !rdmaDone && cmdBits == rdField && !cmdBits[2]
                                 && txpBit && !state.reloaded |=> !active && donePulse)
    else $error("reissued dma without reload did not complete");

endmodule

// >>> design/ncr_command_reg.sv
// command register of the network controller core
// assumes host requests arrive already synchronous to clock
// What this block does
// - writing stop high takes the core offline; no new packets move.
// - traffic already under way finishes before a stop enters the reset state; an error reset enters it at once.
// - core leaves stop only when stop is cleared and start set.
// - reaching the reset state raises the reset-complete status flag.
// - after power-up stop reads high and start reads low.
// - stop written together with start while running leaves both stop and start set.
// - setting start reactivates the core after power-up, stop or error.
// - transmit bit starts a packet and self-clears on completion or abort.
// - writing zero to the transmit bit changes nothing.
// - reissued dma with transmit and no count reload completes at once.
// - page select, abort and stop writes are accepted at any time.
// - three bits command the remote dma; the top bit aborts it.
// - abort leaves the remote address advanced, not restored.
// - dma code 000 refused, 001 read, 010 write, 011 send, 1xx abort.
// - top two bits pick register page 0, 1, 2 or 3.
module ncr_command_reg import ncr_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ce,
  // host register access
  input  ncr_req_t        hostReq,
  output logic [7:0]      regRdata,
  // core status
  input  ncr_core_t       core,
  // core control
  output logic            coreOnline,
  output logic            txStart,
  output logic            txPending,
  // remote dma control
  output ncr_rdma_t       rdmaCmd,
  output logic            rdmaActive,
  output logic            rdmaStart,
  output logic            rdmaAbort,
  output logic            rdmaComplete,
  // status
  output logic            resetDone,
  // page selection
  output logic [1:0]      pageSel,
  output logic [3:0]      pageOneHot
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] ps;
    logic       transmit_packet_bit;
    logic       start_run_bit;
    logic       stop_reset_bit;
    logic [7:0] rdata;
    logic       txStart;
  } ncr_main_state_t;

  ncr_main_state_t state;
  ncr_main_state_t next_state;

  logic       wrCmd;
  logic       rdCmd;
  logic       wrStop;
  logic       wrStart;
  logic       wrTxp;
  logic       txEnd;
  logic [2:0] rdField;
  logic       busy;
  logic [7:0] cmdValue;
  ncr_run_t   runState;

  // ==========================================================
  // decode
  assign wrCmd   = hostReq.wr && hostReq.addr == NCR_CMD_OFFSET;
  assign rdCmd   = hostReq.rd && hostReq.addr == NCR_CMD_OFFSET;
  assign wrStop  = wrCmd && hostReq.wdata[NCR_STOP_POS];
  assign wrStart = wrCmd && !hostReq.wdata[NCR_STOP_POS] && hostReq.wdata[NCR_START_POS];
  assign wrTxp   = wrCmd && hostReq.wdata[NCR_TXP_POS];
  assign txEnd   = core.txDone || core.txAbort;
  assign busy    = core.txBusy || core.rxBusy;

  always_comb begin
    cmdValue = NCR_READ_EMPTY;
    cmdValue[NCR_PS_MSB:NCR_PS_LSB] = state.ps;
    cmdValue[NCR_RD_MSB:NCR_RD_LSB] = rdField;
    cmdValue[NCR_TXP_POS]           = state.transmit_packet_bit;
    cmdValue[NCR_START_POS]         = state.start_run_bit;
    cmdValue[NCR_STOP_POS]          = state.stop_reset_bit;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state         = state;
    next_state.txStart = 1'b0;
    if (wrCmd) begin
      next_state.ps  = hostReq.wdata[NCR_PS_MSB:NCR_PS_LSB];
      // stored as written, so stop over start reads back both set
      next_state.stop_reset_bit = hostReq.wdata[NCR_STOP_POS];
      next_state.start_run_bit = hostReq.wdata[NCR_START_POS];
    end
    // clear before set, but a new command in the ending cycle is dropped while the bit still reads set
    if (txEnd) begin
      next_state.transmit_packet_bit = 1'b0;
    end
    // a zero in the transmit bit leaves it untouched
    if (wrTxp && coreOnline && !wrStop && !state.transmit_packet_bit) begin
      next_state.transmit_packet_bit     = 1'b1;
      next_state.txStart = 1'b1;
    end
    if (rdCmd) begin
      next_state.rdata = cmdValue;
    end else if (hostReq.rd) begin
      next_state.rdata = NCR_READ_EMPTY;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state.ps      <= NCR_CMD_RESET[NCR_PS_MSB:NCR_PS_LSB];
      state.transmit_packet_bit     <= NCR_CMD_RESET[NCR_TXP_POS];
      state.start_run_bit     <= NCR_CMD_RESET[NCR_START_POS];
      state.stop_reset_bit     <= NCR_CMD_RESET[NCR_STOP_POS];
      state.rdata   <= NCR_READ_EMPTY;
      state.txStart <= 1'b0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // stop and start sequencing
  ncr_run_ctrl u_run (
    .clock     (clock),
    .resetn    (resetn),
    .ce        (ce),
    .stopCmd   (wrStop),
    .startCmd  (wrStart),
    .busy      (busy),
    .errReset  (core.errReset),
    .rstClear  (core.isrRstClear),
    .runState  (runState),
    .resetDone (resetDone)
  );

  // ==========================================================
  // remote dma command channel
  ncr_rdma_ctrl u_rdma (
    .clock      (clock),
    .resetn     (resetn),
    .ce         (ce),
    .cmdWrite   (wrCmd),
    .cmdBits    (hostReq.wdata[NCR_RD_MSB:NCR_RD_LSB]),
    .txpBit     (hostReq.wdata[NCR_TXP_POS]),
    .rdmaDone   (core.rdmaDone),
    .rbcWrite   (core.rbcWrite),
    .rdField    (rdField),
    .active     (rdmaActive),
    .startPulse (rdmaStart),
    .abortPulse (rdmaAbort),
    .donePulse  (rdmaComplete)
  );

  // ==========================================================
  // outputs
  // draining still lets current frames finish but no new ones begin
  assign coreOnline = runState == NCR_RUNNING;
  assign txStart    = state.txStart;
  assign txPending  = state.transmit_packet_bit;
  assign rdmaCmd    = ncrDecodeRdma(rdField);
  assign regRdata   = state.rdata;
  assign pageSel    = state.ps;
  assign pageOneHot = ncrPageDecode(state.ps);

  // ==========================================================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence stopWrite;
    ce && wrStop;
  endsequence

  sequence txRequest;
    ce && wrTxp && coreOnline && !wrStop && !state.transmit_packet_bit;
  endsequence

  sequence txFinish;
    ce && state.transmit_packet_bit && txEnd && !wrTxp;
  endsequence

  stop_offline_a: assert property (stopWrite |=> !coreOnline)
    else $error("core still online after stop");

  // a stop rewritten while already stopped keeps the flag it has
  stop_drain_a: assert property (stopWrite ##0 busy && runState != NCR_STOPPED |=> !coreOnline && !resetDone)
    else $error("stop completed while traffic busy");

  power_up_a: assert property ($rose(resetn) |-> state.stop_reset_bit && !state.start_run_bit && !coreOnline)
    else $error("wrong state after power-up");

  both_set_a: assert property (stopWrite ##0 coreOnline && hostReq.wdata[NCR_START_POS]
                               |=> state.stop_reset_bit && state.start_run_bit)
    else $error("stop over start did not keep both bits");

  tx_begin_a: assert property (txRequest |=> txStart && txPending ##1 !txStart)
    else $error("transmit start missing or not one cycle");

  tx_clear_a: assert property (txFinish |=> !txPending)
    else $error("transmit bit not cleared on end");

  tx_zero_a: assert property (ce && wrCmd && !hostReq.wdata[NCR_TXP_POS] && state.transmit_packet_bit && !txEnd
                              |=> txPending && !txStart)
    else $error("writing zero disturbed transmit");

  stopped_no_tx_a: assert property (ce && !coreOnline |=> !txStart)
    else $error("transmit started while offline");

  page_write_a: assert property (ce && wrCmd |=> pageSel == $past(hostReq.wdata[NCR_PS_MSB:NCR_PS_LSB])
                                 && pageOneHot[pageSel])
    else $error("page select not taken");

  read_back_a: assert property (ce && rdCmd && !wrCmd |=> regRdata == $past(cmdValue))
    else $error("command read data wrong");

  // ==========================================================
  // checks: run state and reset flag
  sequence startWrite;
    ce && wrStart && !core.errReset;
  endsequence

  start_online_a: assert property (startWrite |=> coreOnline)
    else $error("start write did not bring core online");

  stay_offline_a: assert property (ce && !coreOnline && !wrStart |=> !coreOnline)
    else $error("core left stop without start");

  flag_hold_a: assert property (ce && resetDone && !core.isrRstClear && !wrStart |=> resetDone)
    else $error("reset-complete flag dropped on its own");

  flag_clear_a: assert property (ce && resetDone && core.isrRstClear && !wrStart |=> !resetDone)
    else $error("reset-complete flag not cleared");

  err_offline_a: assert property (ce && coreOnline && core.errReset && !wrStop |=> !coreOnline && resetDone)
    else $error("error reset did not stop core");

  // ==========================================================
  // checks: transmit bit
  stop_no_tx_a: assert property (ce && wrTxp && wrStop |=> !txStart)
    else $error("transmit started together with stop");

  txp_hold_a: assert property (ce && txPending && !txEnd |=> txPending)
    else $error("transmit bit cleared without an end");

  // ==========================================================
  // checks: remote dma field and pages
  sequence dmaRequest;
    ce && wrCmd && !rdmaActive && !hostReq.wdata[NCR_RD_MSB] && hostReq.wdata[NCR_RD_MSB-1:NCR_RD_LSB] != 2'h0;
  endsequence

  dma_start_a: assert property (dmaRequest |=> rdmaStart && rdmaActive
                                && rdField == $past(hostReq.wdata[NCR_RD_MSB:NCR_RD_LSB]))
    else $error("remote dma command not started");

  dma_none_a: assert property (ce && wrCmd && hostReq.wdata[NCR_RD_MSB:NCR_RD_LSB] == 3'h0 && !core.rdmaDone
                               |=> !rdmaStart && rdField == $past(rdField))
    else $error("refused dma code changed the field");

  abort_any_a: assert property (ce && wrCmd && hostReq.wdata[NCR_RD_MSB]
                                |=> !rdmaActive && rdmaCmd == NCR_RD_ABORT)
    else $error("abort write not taken");

  page_hold_a: assert property (ce && !wrCmd |=> $stable(pageSel))
    else $error("page select moved without a write");

  read_other_a: assert property (ce && hostReq.rd && !rdCmd |=> regRdata == NCR_READ_EMPTY)
    else $error("read of other address not empty");

endmodule

// >>> test/ncr_core_model.sv
// behavioural stand-in for the transmit and remote dma engines
// assumes the command register's pulses are registered on the same clock
module ncr_core_model import ncr_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // requests from the command register
  input  wire logic       txStart,
  input  wire logic       rdmaStart,
  input  wire logic       rdmaStop,
  // lengths chosen by the bench
  input  wire logic [7:0] txLen,
  input  wire logic [7:0] rdmaLen,
  // engine status
  output logic            txBusy,
  output logic            txDone,
  output logic            rdmaDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txCnt;
  logic [7:0] dmaCnt;
  logic       dmaRun;

  // ==========================================================
  // frame and dma countdown
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txBusy   <= 1'b0;
      txDone   <= 1'b0;
      rdmaDone <= 1'b0;
      txCnt    <= 8'h00;
      dmaCnt   <= 8'h00;
      dmaRun   <= 1'b0;
    end else begin
      txDone   <= 1'b0;
      rdmaDone <= 1'b0;
      if (txStart) begin
        txBusy <= 1'b1;
        txCnt  <= txLen;
      end else if (txBusy) begin
        // a frame once begun runs out its length unless a new txStart reloads the count
        if (txCnt == 8'h00) begin
          txBusy <= 1'b0;
          txDone <= 1'b1;
        end else begin
          txCnt <= txCnt - 8'h01;
        end
      end
      if (rdmaStart) begin
        dmaRun <= 1'b1;
        dmaCnt <= rdmaLen;
      end else if (rdmaStop) begin
        dmaRun <= 1'b0;
      end else if (dmaRun) begin
        if (dmaCnt == 8'h00) begin
          dmaRun   <= 1'b0;
          rdmaDone <= 1'b1;
        end else begin
          dmaCnt <= dmaCnt - 8'h01;
        end
      end
    end
  end
endmodule

// >>> test/nic_command_register_tb_top.sv
// self-checking bench for the controller command register
// assumes host accesses are driven on the falling edge, one access at a time
module nic_command_register_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ncr_pkg::*;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       ce = 1'b1;
  ncr_req_t   hostReq = '0;
  logic       rxBusy = 1'b0;
  logic       rbcW = 1'b0;
  logic       errR = 1'b0;
  logic       clrR = 1'b0;
  logic       abortR = 1'b0;
  logic [7:0] rdmaLen = 8'h04;
  logic       txBusyM, txDoneM, rdmaDoneM;
  ncr_core_t  coreS;
  logic [7:0] regRdata;
  logic       coreOnline, txStart, txPending, rdmaActive, rdmaStart;
  logic       rdmaAbort, rdmaComplete, resetDone;
  ncr_rdma_t  rdmaCmd;
  logic [1:0] pageSel;
  logic [3:0] pageOneHot;
  int         mismatches = 0;
  int         check_count = 0;

  assign coreS = '{txBusy: txBusyM, rxBusy: rxBusy, txDone: txDoneM, txAbort: abortR,
                   rdmaDone: rdmaDoneM, rbcWrite: rbcW, errReset: errR, isrRstClear: clrR};
  always #4 clock = ~clock;

  ncr_command_reg dut (.clock(clock), .resetn(resetn), .ce(ce), .hostReq(hostReq),
    .regRdata(regRdata), .core(coreS), .coreOnline(coreOnline), .txStart(txStart),
    .txPending(txPending), .rdmaCmd(rdmaCmd), .rdmaActive(rdmaActive), .rdmaStart(rdmaStart),
    .rdmaAbort(rdmaAbort), .rdmaComplete(rdmaComplete), .resetDone(resetDone),
    .pageSel(pageSel), .pageOneHot(pageOneHot));
  ncr_core_model model (.clock(clock), .resetn(resetn), .txStart(txStart), .rdmaStart(rdmaStart),
    .rdmaStop(rdmaAbort | rdmaComplete), .txLen(8'h05), .rdmaLen(rdmaLen), .txBusy(txBusyM),
    .txDone(txDoneM), .rdmaDone(rdmaDoneM));

  // ==========================================================
  // access and checking tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrc(input logic [7:0] d);
    @(negedge clock);
    hostReq.wr = 1'b1;
    hostReq.addr = NCR_CMD_OFFSET;
    hostReq.wdata = d;
    @(negedge clock);
    hostReq.wr = 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clock);
    hostReq.rd = 1'b1;
    hostReq.addr = a;
    @(negedge clock);
    hostReq.rd = 1'b0;
    chk("regRdata", regRdata, exp);
  endtask

  // 0 error reset, 1 status clear, 2 byte count written, 3 transmit aborted
  task automatic pulse(input int k);
    @(negedge clock);
    errR = (k == 0);
    clrR = (k == 1);
    rbcW = (k == 2);
    abortR = (k == 3);
    @(negedge clock);
    errR = 1'b0;
    clrR = 1'b0;
    rbcW = 1'b0;
    abortR = 1'b0;
  endtask

  // 0 txPending low, 1 resetDone high, 2 rdmaComplete high
  task automatic waitsig(input int w);
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      if ((w == 0 && txPending === 1'b0) || (w == 1 && resetDone === 1'b1) ||
          (w == 2 && rdmaComplete === 1'b1)) begin
        return;
      end
    end
    mismatches++;
    $display("unexpected timeout on wait %0d", w);
    conclude();
  endtask

  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    rdc(NCR_CMD_OFFSET, 8'h21);
    chk("coreOnline", 8'(coreOnline), 8'h00);
    chk("pageOneHot", 8'(pageOneHot), 8'h01);
    $display("test reset done");

    wrc(8'h23);
    chk("coreOnline", 8'(coreOnline), 8'h00);
    wrc(8'h22);
    chk("coreOnline", 8'(coreOnline), 8'h01);
    chk("resetDone", 8'(resetDone), 8'h00);
    $display("test start done");

    // byte count and page start taken as already programmed
    wrc(8'h26);
    chk("txStart", 8'(txStart), 8'h01);
    wrc(8'h22);
    chk("txPending", 8'(txPending), 8'h01);
    waitsig(0);
    rdc(NCR_CMD_OFFSET, 8'h22);
    wrc(8'h26);
    pulse(3);
    chk("txPending", 8'(txPending), 8'h00);
    $display("test transmit done");

    wrc(8'h26);
    rxBusy = 1'b1;
    wrc(8'h23);
    chk("coreOnline", 8'(coreOnline), 8'h00);
    chk("resetDone", 8'(resetDone), 8'h00);
    waitsig(0);
    chk("resetDone", 8'(resetDone), 8'h00);
    rxBusy = 1'b0;
    waitsig(1);
    chk("txBusy", 8'(txBusyM), 8'h00);
    rdc(NCR_CMD_OFFSET, 8'h23);
    wrc(8'h25);
    chk("txStart", 8'(txStart), 8'h00);
    pulse(1);
    chk("resetDone", 8'(resetDone), 8'h00);
    wrc(8'h22);
    chk("coreOnline", 8'(coreOnline), 8'h01);
    $display("test stop done");

    pulse(0);
    chk("coreOnline", 8'(coreOnline), 8'h00);
    chk("resetDone", 8'(resetDone), 8'h01);
    wrc(8'h22);
    chk("coreOnline", 8'(coreOnline), 8'h01);
    $display("test error reset done");

    wrc(8'h02);
    chk("rdmaStart", 8'(rdmaStart), 8'h00);
    // read dma begins while this frame is still going out
    wrc(8'h26);
    for (int c = 1; c < 4; c++) begin
      rdmaLen = (c == 1) ? 8'h04 : 8'hFF;
      wrc({2'b00, 3'(c), 3'b010});
      chk("rdmaStart", 8'(rdmaStart), 8'h01);
      chk("rdmaCmd", 8'(rdmaCmd), 8'(c));
      if (c == 1) begin
        chk("txPending", 8'(txPending), 8'h01);
        waitsig(2);
      end else if (c == 2) begin
        wrc(8'h52);
        chk("pageSel", 8'(pageSel), 8'h01);
        chk("rdmaActive", 8'(rdmaActive), 8'h01);
        wrc(8'h22);
        chk("rdmaAbort", 8'(rdmaAbort), 8'h01);
        pulse(2);
      end else begin
        // same code kept alongside the transmit bit
        wrc(8'h1E);
        chk("rdmaComplete", 8'(rdmaComplete), 8'h01);
        chk("txStart", 8'(txStart), 8'h01);
        waitsig(0);
      end
      chk("rdmaActive", 8'(rdmaActive), 8'h00);
      chk("rdmaCmd", 8'(rdmaCmd), 8'(NCR_RD_ABORT));
    end
    $display("test remote dma done");

    for (int p = 0; p < 4; p++) begin
      wrc({2'(p), 6'h22});
      chk("pageSel", 8'(pageSel), 8'(p));
      chk("pageOneHot", 8'(pageOneHot), 8'h01 << p);
      rdc(NCR_CMD_OFFSET, {2'(p), 6'h22});
    end
    // clock enable low: a write must not land
    ce = 1'b0;
    wrc(8'h22);
    chk("pageSel", 8'(pageSel), 8'h03);
    ce = 1'b1;
    rdc(4'h5, NCR_READ_EMPTY);
    $display("test pages done");
    conclude();
  end
endmodule
